// [logic/tmf_params.svh]
// Offsets, bit positions and reset values of the timer mask/flag registers
`ifndef TMF_PARAMS_SVH
`define TMF_PARAMS_SVH
`define TMF_IO_FLAGS 8'h36
`define TMF_IO_MASK 8'h37
`define TMF_IO_TO_DATA 8'h20
`define TMF_ADDR_FLAGS 8'h56
`define TMF_ADDR_MASK 8'h57
`define TMF_ADDR_XFLAGS 8'h7c
`define TMF_ADDR_XMASK 8'h7d
`define TMF_RESET_VAL 8'h00
`define TMF_BIT_CAP 5
`define TMF_BIT_CMP_A 4
`define TMF_BIT_CMP_B 3
`define TMF_BIT_OVF 2
`define TMF_BIT_T3_CMP_C 1
`define TMF_BIT_T1_CMP_C 0
`define TMF_T1_USED 8'h3c
`define TMF_X_USED 8'h3f
`endif

// [logic/tmf_pkg.sv]
// Types shared by the timer mask/flag logic
package tmf_pkg;
	// Raw event strobes from one 16-bit timer, same clock
	typedef struct packed {
		logic tick;
		logic capture;
		logic capture_is_top;
		logic top_hit;
		logic cmp_a;
		logic cmp_b;
		logic cmp_c;
		logic overflow;
		logic force_a;
		logic force_b;
		logic force_c;
	} tmf_evt_t;
	// Processor I/O access
	typedef struct packed {
		logic [7:0] addr;
		logic wr;
		logic [7:0] wdata;
	} tmf_io_t;
endpackage

// [logic/tmf_irq_flags.sv]
// Interrupt mask and flag logic for timers 1 and 3
`timescale 1ns/1ps
`include "tmf_params.svh"
// What this block does
// - Request needs enable, global enable, and flag
// - Primary mask holds timer 1 enables
// - Extended mask holds timer 3, t1 compare C
// - Extended mask unavailable in legacy mode
// - Extended flags hold timer 3, t1 compare C
// - Capture pin event sets capture flag
// - Capture-as-top reaching top sets capture flag
// - Compare flag set on the tick of the match
// - Forced compare never sets compare flag
// - Overflow strobe sets overflow flag
// - Vector execution clears its flag
// - Writing one clears a flag
// - Primary flags at I/O 0x36, data 0x56
// - Primary mask at I/O 0x37, resets zero
module tmf_irq_flags (
	// Clock and reset
	input wire logic clk,
	input wire logic reset_n,
	// Processor data-space register access
	input wire tmf_pkg::tmf_io_t io,
	output logic [7:0] io_rdata,
	// Core state
	input wire logic global_ie,
	input wire logic legacy_mode,
	input wire logic [7:0] vec_ack_main,
	input wire logic [7:0] vec_ack_ext,
	// Timer event strobes
	input wire tmf_pkg::tmf_evt_t t1_evt,
	input wire tmf_pkg::tmf_evt_t t3_evt,
	// Interrupt requests, laid out like the flag registers
	output logic [7:0] irq_main,
	output logic [7:0] irq_ext
);
	logic [7:0] mask_q;
	logic [7:0] xmask_q;
	logic [7:0] flags_q;
	logic [7:0] xflags_q;
	logic [7:0] set_main;
	logic [7:0] set_ext;
	logic [7:0] clr_main;
	logic [7:0] clr_ext;
	logic wr_mask;
	logic wr_xmask;
	logic wr_flags;
	logic wr_xflags;

	// Address decode; core adds the I/O offset itself
	assign wr_mask = io.wr && io.addr == `TMF_ADDR_MASK;
	assign wr_flags = io.wr && io.addr == `TMF_ADDR_FLAGS;
	assign wr_xmask = io.wr && io.addr == `TMF_ADDR_XMASK && !legacy_mode;
	assign wr_xflags = io.wr && io.addr == `TMF_ADDR_XFLAGS;

	// Hardware sets, only on a timer tick; a compare match sets its flag on the tick it comes with
	always_comb
	begin
		set_main = 8'h00;
		set_ext = 8'h00;
		set_main[`TMF_BIT_CAP] = t1_evt.tick && (t1_evt.capture ||
			(t1_evt.capture_is_top && t1_evt.top_hit));
		set_main[`TMF_BIT_CMP_A] = t1_evt.tick && t1_evt.cmp_a;
		set_main[`TMF_BIT_CMP_B] = t1_evt.tick && t1_evt.cmp_b;
		set_main[`TMF_BIT_OVF] = t1_evt.tick && t1_evt.overflow;
		set_ext[`TMF_BIT_CAP] = t3_evt.tick && (t3_evt.capture ||
			(t3_evt.capture_is_top && t3_evt.top_hit));
		set_ext[`TMF_BIT_CMP_A] = t3_evt.tick && t3_evt.cmp_a;
		set_ext[`TMF_BIT_CMP_B] = t3_evt.tick && t3_evt.cmp_b;
		set_ext[`TMF_BIT_OVF] = t3_evt.tick && t3_evt.overflow;
		set_ext[`TMF_BIT_T3_CMP_C] = t3_evt.tick && t3_evt.cmp_c;
		set_ext[`TMF_BIT_T1_CMP_C] = t1_evt.tick && t1_evt.cmp_c;
	end

	// Clears from vector execution and write-one; zero bits do nothing
	assign clr_main = (vec_ack_main | (wr_flags ? io.wdata : 8'h00))
		& `TMF_T1_USED;
	assign clr_ext = (vec_ack_ext | (wr_xflags ? io.wdata : 8'h00))
		& `TMF_X_USED;

	// Mask registers; other timers' bits are not held here
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			mask_q <= `TMF_RESET_VAL;
			xmask_q <= `TMF_RESET_VAL;
		end
		else
		begin
			if (wr_mask)
				mask_q <= io.wdata & `TMF_T1_USED;
			if (wr_xmask)
				xmask_q <= io.wdata & `TMF_X_USED;
		end
	end

	// Flags: set wins over a clear in the same cycle
	always_ff @(posedge clk)
	begin
		if (!reset_n)
		begin
			flags_q <= `TMF_RESET_VAL;
			xflags_q <= `TMF_RESET_VAL;
		end
		else
		begin
			flags_q <= (flags_q & ~clr_main) | set_main;
			xflags_q <= (xflags_q & ~clr_ext) | set_ext;
		end
	end

	// Read mux; legacy mode hides the extended mask
	always_ff @(posedge clk)
	begin
		if (!reset_n)
			io_rdata <= 8'h00;
		else
		begin
			unique case (io.addr)
				`TMF_ADDR_MASK: io_rdata <= mask_q;
				`TMF_ADDR_FLAGS: io_rdata <= flags_q;
				`TMF_ADDR_XMASK: io_rdata <= legacy_mode ? 8'h00 : xmask_q;
				`TMF_ADDR_XFLAGS: io_rdata <= xflags_q;
				default: io_rdata <= 8'h00;
			endcase
		end
	end

	// Requests are combinational so an ack drops them next cycle
	assign irq_main = global_ie ? (mask_q & flags_q) : 8'h00;
	assign irq_ext = (global_ie && !legacy_mode) ? (xmask_q & xflags_q) : 8'h00;

	// Checks
	a_irq_gating: assert property (@(posedge clk) disable iff (!reset_n)
		(irq_main != 8'h00) |-> (global_ie && (irq_main & ~(mask_q & flags_q)) == 8'h00))
		else $error("timer request without enable or flag");
	a_cmp_sets_flag: assert property (@(posedge clk) disable iff (!reset_n)
		(t1_evt.tick && t1_evt.cmp_a) |=> flags_q[`TMF_BIT_CMP_A])
		else $error("compare A match did not set flag");
	a_force_no_flag: assert property (@(posedge clk) disable iff (!reset_n)
		(t1_evt.force_b && !(t1_evt.tick && t1_evt.cmp_b) && !flags_q[`TMF_BIT_CMP_B])
		|=> !flags_q[`TMF_BIT_CMP_B])
		else $error("forced compare set flag");
	a_cap_top_sets: assert property (@(posedge clk) disable iff (!reset_n)
		(t3_evt.tick && t3_evt.capture_is_top && t3_evt.top_hit) |=> xflags_q[`TMF_BIT_CAP])
		else $error("top reach did not set capture flag");
	a_ack_clears: assert property (@(posedge clk) disable iff (!reset_n)
		(vec_ack_ext != 8'h00)
		|=> (xflags_q & $past(vec_ack_ext) & ~$past(set_ext)) == 8'h00)
		else $error("vector execution did not clear extended flag");
	a_ack_clears_main: assert property (@(posedge clk) disable iff (!reset_n)
		(vec_ack_main != 8'h00)
		|=> (flags_q & $past(vec_ack_main) & ~$past(set_main)) == 8'h00)
		else $error("vector execution did not clear flag");
	a_w1c_clears: assert property (@(posedge clk) disable iff (!reset_n)
		(wr_flags && io.wdata[`TMF_BIT_CAP] && !set_main[`TMF_BIT_CAP])
		|=> !flags_q[`TMF_BIT_CAP])
		else $error("write one did not clear capture flag");
	a_zero_keeps: assert property (@(posedge clk) disable iff (!reset_n)
		(wr_xflags && vec_ack_ext == 8'h00)
		|=> ((xflags_q ^ $past(xflags_q)) & ~$past(io.wdata) & ~$past(set_ext)) == 8'h00)
		else $error("zero write changed a flag");
	a_set_beats_clr: assert property (@(posedge clk) disable iff (!reset_n)
		((set_main & clr_main) != 8'h00)
		|=> (flags_q & $past(set_main)) == $past(set_main))
		else $error("clear beat a same-cycle set");

	// Legacy mode: extended mask reads zero and ignores writes
	a_legacy_hides: assert property (@(posedge clk) disable iff (!reset_n)
		(legacy_mode && io.addr == `TMF_ADDR_XMASK) |=> io_rdata == 8'h00)
		else $error("extended mask visible in legacy mode");
	a_legacy_no_write: assert property (@(posedge clk) disable iff (!reset_n)
		(legacy_mode && io.wr && io.addr == `TMF_ADDR_XMASK) |=> xmask_q == $past(xmask_q))
		else $error("extended mask written in legacy mode");

	// Register writes and reads; unused bits never hold a one
	a_mask_write: assert property (@(posedge clk) disable iff (!reset_n)
		wr_mask |=> mask_q == ($past(io.wdata) & `TMF_T1_USED))
		else $error("mask write lost");
	a_xmask_write: assert property (@(posedge clk) disable iff (!reset_n)
		wr_xmask |=> xmask_q == ($past(io.wdata) & `TMF_X_USED))
		else $error("extended mask write lost");
	a_unused_zero: assert property (@(posedge clk) disable iff (!reset_n)
		((flags_q | mask_q) & ~`TMF_T1_USED) == 8'h00 &&
		((xflags_q | xmask_q) & ~`TMF_X_USED) == 8'h00)
		else $error("unused register bit set");
	a_read_flags: assert property (@(posedge clk) disable iff (!reset_n)
		(io.addr == `TMF_ADDR_FLAGS) |=> io_rdata == $past(flags_q))
		else $error("flag register read wrong");
	a_read_xflags: assert property (@(posedge clk) disable iff (!reset_n)
		(io.addr == `TMF_ADDR_XFLAGS) |=> io_rdata == $past(xflags_q))
		else $error("extended flag register read wrong");

	// Request outputs of both groups
	a_irq_ext_gating: assert property (@(posedge clk) disable iff (!reset_n)
		(irq_ext != 8'h00) |-> (global_ie && !legacy_mode &&
		(irq_ext & ~(xmask_q & xflags_q)) == 8'h00))
		else $error("extended request without enable or flag");
	a_irq_raised: assert property (@(posedge clk) disable iff (!reset_n)
		(global_ie && !legacy_mode) |-> (irq_main == (mask_q & flags_q) &&
		irq_ext == (xmask_q & xflags_q)))
		else $error("pending enabled request not raised");

	// Event strobes that must leave their flag set, or must not
	a_cap_pin_sets: assert property (@(posedge clk) disable iff (!reset_n)
		(t1_evt.tick && t1_evt.capture) |=> flags_q[`TMF_BIT_CAP])
		else $error("capture event did not set flag");
	a_ovf_sets: assert property (@(posedge clk) disable iff (!reset_n)
		(t3_evt.tick && t3_evt.overflow) |=> xflags_q[`TMF_BIT_OVF])
		else $error("overflow did not set flag");
	a_t1_cmp_c_sets: assert property (@(posedge clk) disable iff (!reset_n)
		(t1_evt.tick && t1_evt.cmp_c) |=> xflags_q[`TMF_BIT_T1_CMP_C])
		else $error("timer 1 compare C did not set flag");
	a_no_tick_no_set: assert property (@(posedge clk) disable iff (!reset_n)
		(!t1_evt.tick && !flags_q[`TMF_BIT_CMP_A]) |=> !flags_q[`TMF_BIT_CMP_A])
		else $error("compare flag set without a tick");
	a_force_c_no_flag: assert property (@(posedge clk) disable iff (!reset_n)
		(t3_evt.force_c && !(t3_evt.tick && t3_evt.cmp_c) && !xflags_q[`TMF_BIT_T3_CMP_C])
		|=> !xflags_q[`TMF_BIT_T3_CMP_C])
		else $error("forced compare C set flag");
endmodule

// [sim/tmf_core.sv]
// Processor core stand-in for the timer mask/flag block
`timescale 1ns/1ps
module tmf_core (
	// Clock and block outputs
	input wire logic clk,
	input wire logic [7:0] io_rdata,
	input wire logic [7:0] irq_main,
	input wire logic [7:0] irq_ext,
	// Vector execution allowed
	input wire logic take_vec,
	// Drives into the block
	output tmf_pkg::tmf_io_t io,
	output logic [7:0] vec_ack_main,
	output logic [7:0] vec_ack_ext
);
	initial
	begin
		io = '0;
		vec_ack_main = 8'h00;
		vec_ack_ext = 8'h00;
	end
	// Takes all pending vectors; masking the last ack avoids a double take
	always @(posedge clk)
	begin
		vec_ack_main <= take_vec ? irq_main & ~vec_ack_main : 8'h00;
		vec_ack_ext <= take_vec ? irq_ext & ~vec_ack_ext : 8'h00;
	end
	// Short I/O offsets gain 0x20 on the data path
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		#1 io = '{(a < 8'h40) ? a + 8'h20 : a, 1'b1, d};
		@(posedge clk);
		#1 io.wr = 1'b0;
	endtask
	// Read data is taken one cycle after the address
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		#1 io = '{(a < 8'h40) ? a + 8'h20 : a, 1'b0, 8'h00};
		@(posedge clk);
		#1 d = io_rdata;
	endtask
endmodule

// [sim/tmf_irq_flags_tb.sv]
// Self-checking bench for the timer mask/flag block
`timescale 1ns/1ps
module tmf_irq_flags_tb;
	// Event pulses for timers 1 and 3 and the flags they must leave
	typedef struct packed {logic [10:0] e1; logic [10:0] e3;
		logic [7:0] fm; logic [7:0] fx;} tmf_row_t;
	tmf_row_t rows [13] = '{'{11'h600, 11'h0, 8'h20, 8'h0}, '{11'h580, 11'h0, 8'h20, 8'h0},
		'{11'h500, 11'h0, 8'h0, 8'h0}, '{11'h440, 11'h0, 8'h10, 8'h0}, '{11'h420, 11'h0, 8'h08, 8'h0},
		'{11'h408, 11'h0, 8'h04, 8'h0}, '{11'h410, 11'h0, 8'h0, 8'h01}, '{11'h407, 11'h0, 8'h0, 8'h0},
		'{11'h040, 11'h0, 8'h0, 8'h0}, '{11'h0, 11'h600, 8'h0, 8'h20}, '{11'h0, 11'h478, 8'h0, 8'h1e},
		'{11'h0, 11'h580, 8'h0, 8'h20}, '{11'h0, 11'h407, 8'h0, 8'h0}};
	logic clk, reset_n, global_ie, legacy_mode, take_vec;
	tmf_pkg::tmf_evt_t t1_evt, t3_evt;
	tmf_pkg::tmf_io_t io;
	logic [7:0] io_rdata, irq_main, irq_ext, vec_ack_main, vec_ack_ext, rd_v;
	int fails = 0;
	int check_count = 0;
	// Block under test and the core facing it
	tmf_irq_flags tmf_irq_flags_inst (.clk, .reset_n, .io, .io_rdata, .global_ie, .legacy_mode,
		.vec_ack_main, .vec_ack_ext, .t1_evt, .t3_evt, .irq_main, .irq_ext);
	tmf_core tmf_core_inst (.clk, .io_rdata, .irq_main, .irq_ext, .take_vec, .io, .vec_ack_main,
		.vec_ack_ext);
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Whole run is a few hundred cycles; ample margin
	initial
	begin
		#50000;
		fails++;
		tally_and_finish;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp)
		begin
			fails++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
		tmf_core_inst.rd(a, rd_v);
		chk(rd_v, exp);
	endtask
	// One-cycle event pulse, sampled on a single edge
	task automatic pulse(input logic [10:0] e1, input logic [10:0] e3);
		@(posedge clk);
		#1 t1_evt = e1;
		t3_evt = e3;
		@(posedge clk);
		#1 t1_evt = '0;
		t3_evt = '0;
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		reset_n = 1'b0;
		global_ie = 1'b0;
		legacy_mode = 1'b0;
		take_vec = 1'b0;
		t1_evt = '0;
		t3_evt = '0;
		repeat (16) @(posedge clk);
		#1 reset_n = 1'b1;
		rchk(8'h36, 8'h00);
		rchk(8'h37, 8'h00);
		rchk(8'h7d, 8'h00);
		// Unused bits stay zero; unmapped reads give zero
		tmf_core_inst.wr(8'h37, 8'hff);
		rchk(8'h37, 8'h3c);
		tmf_core_inst.wr(8'h7d, 8'hff);
		rchk(8'h7d, 8'h3f);
		rchk(8'h38, 8'h00);
		global_ie = 1'b1;
		foreach (rows[i])
		begin
			pulse(rows[i].e1, rows[i].e3);
			chk(irq_main, rows[i].fm);
			chk(irq_ext, rows[i].fx);
			rchk(8'h36, rows[i].fm);
			rchk(8'h7c, rows[i].fx);
			tmf_core_inst.wr(8'h36, 8'hff);
			tmf_core_inst.wr(8'h7c, 8'hff);
		end
		rchk(8'h7c, 8'h00);
		// Zero write keeps a flag; a set wins over a same-cycle clear
		pulse(11'h440, 11'h0);
		tmf_core_inst.wr(8'h36, 8'h00);
		rchk(8'h36, 8'h10);
		fork
			tmf_core_inst.wr(8'h36, 8'h10);
			pulse(11'h440, 11'h0);
		join
		rchk(8'h36, 8'h10);
		global_ie = 1'b0;
		#1 chk(irq_main, 8'h00);
		// Legacy mode hides the extended mask and its requests
		global_ie = 1'b1;
		legacy_mode = 1'b1;
		pulse(11'h0, 11'h410);
		chk(irq_ext, 8'h00);
		// Zero write to the extended flags leaves the pending bit
		tmf_core_inst.wr(8'h7c, 8'h00);
		rchk(8'h7c, 8'h02);
		tmf_core_inst.wr(8'h7d, 8'h00);
		rchk(8'h7d, 8'h00);
		legacy_mode = 1'b0;
		rchk(8'h7d, 8'h3f);
		chk(irq_ext, 8'h02);
		// Executed vectors clear their own flags
		take_vec = 1'b1;
		repeat (3) @(posedge clk);
		#1 chk(irq_main, 8'h00);
		chk(irq_ext, 8'h00);
		rchk(8'h36, 8'h00);
		// Reset in mid-run clears masks, flags and requests
		take_vec = 1'b0;
		pulse(11'h408, 11'h0);
		chk(irq_main, 8'h04);
		reset_n = 1'b0;
		repeat (2) @(posedge clk);
		#1 reset_n = 1'b1;
		chk(irq_main, 8'h00);
		rchk(8'h36, 8'h00);
		rchk(8'h37, 8'h00);
		rchk(8'h7d, 8'h00);
		tally_and_finish;
	end
endmodule
